// ### logic/address_translation_unit.sv
/*
 * Address translation and protection for instruction fetch and data access.
 * Assumes the core presents one request per path per cycle, loads segment,
 * block and page-table state through the maintenance ports, and runs its
 * own miss handler to search the hashed page table.
 */

`timescale 1ns/1ps
`default_nettype none
module address_translation_unit (
   // Clock and reset
   input  wire logic                                  mclk,
   input  wire logic                                  reset_n,
   // Machine state
   input  wire logic                                  instr_translate_enable,
   input  wire logic                                  data_translate_enable,
   // Requests, index 0 fetch, index 1 data
   input  wire atu_pkg::atu_req_s [1:0]               req,
   // Answers, one cycle after the request
   output atu_pkg::atu_resp_s [1:0]                   resp,
   // Segment register load
   input  wire logic                                  segWrValid,
   input  wire logic [atu_pkg::SEG_SEL_W-1:0]         segWrSel,
   input  wire atu_pkg::atu_seg_s                     segWrData,
   // Block array load
   input  wire logic                                  batWrValid,
   input  wire logic                                  batWrToData,
   input  wire logic [atu_pkg::BAT_SEL_W-1:0]         batWrSel,
   input  wire atu_pkg::atu_bat_s                     batWrData,
   // Translation cache refill and invalidate
   input  wire atu_pkg::atu_tcw_s                     tcWrite,
   input  wire logic                                  tcInvValid,
   input  wire logic [atu_pkg::EA_W-1:0]              tcInvEa,
   // Hashed page table placement
   input  wire logic [atu_pkg::EA_W-1:0]              htabOrg,
   input  wire logic [atu_pkg::HTAB_MASK_W-1:0]       htabMask
);
   atu_pkg::atu_seg_s  seg [atu_pkg::NUM_SEGS];
   atu_pkg::atu_bat_s  block_translation_array [2][atu_pkg::BAT_NUM];

   // Block entry decode, shared by both paths
   function automatic logic batMatch(input atu_pkg::atu_bat_s b, input logic [atu_pkg::EA_W-1:0] ea,
                                     input logic user);
      logic [atu_pkg::BEPI_W-1:0] mask;
      mask     = {{(atu_pkg::BEPI_W-atu_pkg::BL_W){1'b1}}, ~b.bl};
      batMatch = ((ea[atu_pkg::EA_W-1:atu_pkg::BLK_OFS_W] & mask) == (b.bepi & mask)) &&
                 (user ? b.vp : b.vs);
   endfunction

   function automatic logic [atu_pkg::EA_W-1:0] batPa(input atu_pkg::atu_bat_s b,
                                                      input logic [atu_pkg::EA_W-1:0] ea);
      logic [atu_pkg::BEPI_W-1:0] keep;
      keep  = {{(atu_pkg::BEPI_W-atu_pkg::BL_W){1'b0}}, b.bl};
      batPa = {b.brpn | (ea[atu_pkg::EA_W-1:atu_pkg::BLK_OFS_W] & keep),
               ea[atu_pkg::BLK_OFS_W-1:0]};
   endfunction

   function automatic logic batAllows(input logic [1:0] pp, input logic isWrite);
      batAllows = (pp != atu_pkg::PP_NONE) && !(isWrite && pp[0]);
   endfunction

   function automatic logic pageAllows(input logic key, input logic [1:0] pp, input logic isWrite);
      if (!key) begin
         pageAllows = !(isWrite && pp == atu_pkg::PP_RO_PAGE);
      end else begin
         pageAllows = (pp != atu_pkg::PP_NONE) && !(isWrite && pp != atu_pkg::PP_RW);
      end
   endfunction

   // Segment registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < atu_pkg::NUM_SEGS; i++) begin
            seg[i] <= '0;
         end
      end else if (segWrValid) begin
         seg[segWrSel] <= segWrData;
      end
   end

   // Block arrays, loaded by system software
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < atu_pkg::BAT_NUM; i++) begin
               block_translation_array[p][i] <= '0;
            end
         end
      end else if (batWrValid) begin
         block_translation_array[batWrToData][batWrSel] <= batWrData;
      end
   end

   genvar p;

   generate
      for (p = 0; p < 2; p++) begin : gPath
         logic                                enable;
         logic                                isWrite;
         atu_pkg::atu_seg_s                   s;
         logic [atu_pkg::VPN_W-1:0]           vpn;
         logic                                tcHit;
         atu_pkg::atu_tce_s                   tcEnt;
         logic [atu_pkg::BAT_NUM-1:0]         bHit;
         logic [atu_pkg::EA_W-1:0]            bPa;
         logic [1:0]                          bPp;

         logic [atu_pkg::HASH_W-1:0]          hash;
         logic [atu_pkg::HASH_W-1:0]          hashMasked;
         atu_pkg::atu_resp_s                  next_resp;

         assign enable  = (p == atu_pkg::PATH_INSTR) ? instr_translate_enable : data_translate_enable;
         assign isWrite = req[p].acc == atu_pkg::ACC_STORE;
         assign s       = seg[req[p].ea[atu_pkg::EA_W-1:atu_pkg::EA_W-atu_pkg::SEG_SEL_W]];
         // 52-bit virtual address is {vpn, page offset}
         assign vpn     = {s.vsid, req[p].ea[atu_pkg::EA_W-atu_pkg::SEG_SEL_W-1:atu_pkg::PAGE_OFS_W]};

         // Primary hash gives the group address for the miss handler
         assign hash       = s.vsid[atu_pkg::HASH_W-1:0] ^
                             {{(atu_pkg::HASH_W-atu_pkg::PAGE_IDX_W){1'b0}}, vpn[atu_pkg::PAGE_IDX_W-1:0]};
         assign hashMasked = {hash[atu_pkg::HASH_W-1:atu_pkg::HASH_LO_W] & htabMask,
                              hash[atu_pkg::HASH_LO_W-1:0]};

         // Lowest index wins where blocks overlap
         always_comb begin
            bPa = '0;
            bPp = atu_pkg::PP_NONE;

            for (int i = atu_pkg::BAT_NUM - 1; i >= 0; i--) begin
               bHit[i] = batMatch(block_translation_array[p][i], req[p].ea, req[p].user);
               if (bHit[i]) begin
                  bPa = batPa(block_translation_array[p][i], req[p].ea);
                  bPp = block_translation_array[p][i].pp;
               end
            end
         end

         // One cache per path
         atu_tcache uCache (
            .mclk      (mclk),
            .reset_n   (reset_n),
            .lookValid (req[p].valid && enable),
            .lookVpn   (vpn),
            .hit       (tcHit),
            .hitEntry  (tcEnt),
            .wrValid   (tcWrite.valid && (tcWrite.toData == 1'(p))),
            .wrVpn     (tcWrite.vpn),
            .wrPpn     (tcWrite.ppn),
            .wrPp      (tcWrite.pp),
            .wrChanged (tcWrite.changed),
            .invValid  (tcInvValid),
            .invSet    (tcInvEa[atu_pkg::PAGE_OFS_W+atu_pkg::SET_W-1:atu_pkg::PAGE_OFS_W])
         );

         always_comb begin
            next_resp          = '0;
            next_resp.valid    = req[p].valid;
            next_resp.vector   = atu_pkg::VEC_NONE;
            next_resp.missVpn  = vpn;

            next_resp.ptegAddr = htabOrg | {{atu_pkg::PAGE_ENTRY_GROUP_PAD_W{1'b0}}, hashMasked,
                                            {atu_pkg::PAGE_ENTRY_GROUP_OFS_W{1'b0}}};

            if (!enable) begin
               next_resp.pa = req[p].ea;
            end else if (|bHit) begin
               next_resp.blockHit  = 1'b1;
               next_resp.pa        = bPa;
               next_resp.protFault = req[p].valid && !batAllows(bPp, isWrite);
            end else if (tcHit) begin
               next_resp.pa        = {tcEnt.ppn, req[p].ea[atu_pkg::PAGE_OFS_W-1:0]};
               next_resp.protFault = !pageAllows(req[p].user ? s.kp : s.ks, tcEnt.pp, isWrite);
               if (isWrite && !tcEnt.changed && !next_resp.protFault) begin
                  next_resp.miss   = 1'b1;
                  next_resp.vector = atu_pkg::VEC_STORE_MISS;
               end
            end else if (req[p].valid) begin
               next_resp.miss = 1'b1;
               if (p == atu_pkg::PATH_INSTR) begin
                  next_resp.vector = atu_pkg::VEC_IFETCH_MISS;
               end else if (isWrite) begin
                  next_resp.vector = atu_pkg::VEC_STORE_MISS;
               end else begin
                  next_resp.vector = atu_pkg::VEC_LOAD_MISS;
               end
            end
         end

         // Registered at the end of the first stage
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               resp[p] <= '0;
            end else begin
               resp[p] <= next_resp;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ### inc/atu_pkg.sv
/*
 * Shared constants and carriers for the address translation unit.
 * Assumes a 32-bit effective address space and a single processor clock.
 */
`default_nettype none
package atu_pkg;
   // Address geometry
   localparam int EA_W        = 32;
   localparam int PAGE_OFS_W  = 12;
   localparam int SEG_SEL_W   = 4;
   localparam int VSID_W      = 24;
   localparam int PAGE_IDX_W  = 16;
   localparam int VA_W        = VSID_W + PAGE_IDX_W + PAGE_OFS_W;
   localparam int VPN_W       = VSID_W + PAGE_IDX_W;
   localparam int PPN_W       = EA_W - PAGE_OFS_W;
   localparam int NUM_SEGS    = 16;
   // Translation cache: 64 entries, two ways of 32 sets
   localparam int TC_WAYS     = 2;
   localparam int TC_SETS     = 32;
   localparam int SET_W       = 5;
   localparam int TAG_W       = VPN_W - SET_W;
   // Block arrays: 128 Kbyte minimum, mask reaches 256 Mbyte
   localparam int BAT_NUM     = 4;
   localparam int BAT_SEL_W   = 2;
   localparam int BLK_OFS_W   = 17;
   localparam int BEPI_W      = EA_W - BLK_OFS_W;
   localparam int BL_W        = 11;
   // Hashed page table: 64-byte groups of eight 8-byte entries
   localparam int PAGE_ENTRY_GROUP_OFS_W  = 6;
   localparam int HASH_W      = 19;
   localparam int HASH_LO_W   = 10;
   localparam int HTAB_MASK_W = 9;
   localparam int PAGE_ENTRY_GROUP_PAD_W  = EA_W - HASH_W - PAGE_ENTRY_GROUP_OFS_W;
   localparam int PATH_INSTR  = 0;
   localparam int PATH_DATA   = 1;
   // Exception vectors
   localparam logic [19:0] VEC_NONE        = 20'h0_0000;
   localparam logic [19:0] VEC_IFETCH_MISS = 20'h0_1000;
   localparam logic [19:0] VEC_LOAD_MISS   = 20'h0_1100;
   localparam logic [19:0] VEC_STORE_MISS  = 20'h0_1200;
   // Protection codes
   localparam logic [1:0] PP_NONE    = 2'h0;
   localparam logic [1:0] PP_RW      = 2'h2;
   localparam logic [1:0] PP_RO_PAGE = 2'h3;

   typedef enum logic [1:0] {
      ACC_FETCH = 2'b00,
      ACC_LOAD  = 2'b01,
      ACC_STORE = 2'b10,
      ACC_CACHE = 2'b11
   } atu_acc_e;

   typedef struct packed {
      logic            valid;
      atu_acc_e        acc;
      logic            user;
      logic [EA_W-1:0] ea;
   } atu_req_s;

   typedef struct packed {
      logic             valid;
      logic             miss;
      logic             protFault;
      logic             blockHit;
      logic [19:0]      vector;
      logic [EA_W-1:0]  pa;
      logic [EA_W-1:0]  ptegAddr;
      logic [VPN_W-1:0] missVpn;
   } atu_resp_s;

   typedef struct packed {
      logic              ks;
      logic              kp;
      logic [VSID_W-1:0] vsid;
   } atu_seg_s;

   typedef struct packed {
      logic [BEPI_W-1:0] bepi;
      logic [BL_W-1:0]   bl;
      logic              vs;
      logic              vp;
      logic [BEPI_W-1:0] brpn;
      logic [1:0]        pp;
   } atu_bat_s;

   typedef struct packed {
      logic             valid;
      logic             toData;
      logic [VPN_W-1:0] vpn;
      logic [PPN_W-1:0] ppn;
      logic [1:0]       pp;
      logic             changed;
   } atu_tcw_s;

   typedef struct packed {
      logic             valid;
      logic [TAG_W-1:0] tag;
      logic [PPN_W-1:0] ppn;
      logic [1:0]       pp;
      logic             changed;
   } atu_tce_s;
endpackage
`default_nettype wire

// ### logic/atu_tcache.sv
/*
 * Two-way set-associative translation cache of recently used page entries.
 * Assumes lookups are consumed in the same cycle and refills come from
 * the software miss handler through the write port.
 */
`timescale 1ns/1ps
`default_nettype none
module atu_tcache (
   // Clock and reset
   input  wire logic                       mclk,
   input  wire logic                       reset_n,
   // Lookup
   input  wire logic                       lookValid,
   input  wire logic [atu_pkg::VPN_W-1:0]  lookVpn,
   output logic                            hit,
   output atu_pkg::atu_tce_s               hitEntry,
   // Refill
   input  wire logic                       wrValid,
   input  wire logic [atu_pkg::VPN_W-1:0]  wrVpn,
   input  wire logic [atu_pkg::PPN_W-1:0]  wrPpn,
   input  wire logic [1:0]                 wrPp,
   input  wire logic                       wrChanged,
   // Selective invalidate by set
   input  wire logic                       invValid,
   input  wire logic [atu_pkg::SET_W-1:0]  invSet
);
   atu_pkg::atu_tce_s                     ent [atu_pkg::TC_WAYS][atu_pkg::TC_SETS];
   logic [atu_pkg::TC_SETS-1:0]           lru;
   logic [atu_pkg::TC_WAYS-1:0]           wayHit;
   logic [atu_pkg::SET_W-1:0]             lookSet;
   logic [atu_pkg::SET_W-1:0]             wrSet;

   assign lookSet = lookVpn[atu_pkg::SET_W-1:0];
   assign wrSet   = wrVpn[atu_pkg::SET_W-1:0];

   genvar w;
   generate
      for (w = 0; w < atu_pkg::TC_WAYS; w++) begin : gWay
         assign wayHit[w] = ent[w][lookSet].valid &&
                            ent[w][lookSet].tag == lookVpn[atu_pkg::VPN_W-1:atu_pkg::SET_W];
      end
   endgenerate

   assign hit      = lookValid && |wayHit;
   assign hitEntry = wayHit[1] ? ent[1][lookSet] : ent[0][lookSet];

   // Entry storage; refill goes to the least recently used way
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int s = 0; s < atu_pkg::TC_SETS; s++) begin
            for (int v = 0; v < atu_pkg::TC_WAYS; v++) begin
               ent[v][s] <= '0;
            end
         end
      end else begin
         if (invValid) begin
            for (int v = 0; v < atu_pkg::TC_WAYS; v++) begin
               ent[v][invSet].valid <= 1'b0;
            end
         end
         if (wrValid) begin
            ent[lru[wrSet]][wrSet] <= '{valid: 1'b1, tag: wrVpn[atu_pkg::VPN_W-1:atu_pkg::SET_W],
                                       ppn: wrPpn, pp: wrPp, changed: wrChanged};
         end
      end
   end

   // Replacement state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lru <= '0;
      end else if (wrValid) begin
         lru[wrSet] <= ~lru[wrSet];
      end else if (hit) begin
         lru[lookSet] <= ~wayHit[1];
      end
   end
endmodule
`default_nettype wire

// ### verification/atu_asserts.sv
/* Checker for the address translation unit top module ports.
   Assumes one clock, asynchronous active-low reset, answers one cycle after requests. */
`timescale 1ns/1ps
`default_nettype none
module atu_checker (
   // Clock and reset
   input wire logic                      mclk,
   input wire logic                      reset_n,
   // Watched ports
   input wire logic                      instr_translate_enable,
   input wire logic                      data_translate_enable,
   input wire atu_pkg::atu_req_s [1:0]  req,
   input wire atu_pkg::atu_resp_s [1:0] resp
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   property p_fetch_answer;
      $past(reset_n) |-> resp[0].valid == $past(req[0].valid);
   endproperty
   a_fetch_answer: assert property (p_fetch_answer) else $error("fetch answer late");
   property p_data_answer;
      $past(reset_n) |-> resp[1].valid == $past(req[1].valid);
   endproperty
   a_data_answer: assert property (p_data_answer) else $error("data answer late");
   property p_fetch_pass;
      $past(reset_n) && $past(req[0].valid) && !$past(instr_translate_enable)
         |-> resp[0].pa == $past(req[0].ea) && !resp[0].miss;
   endproperty
   a_fetch_pass: assert property (p_fetch_pass) else $error("fetch address altered");
   property p_data_pass;
      $past(reset_n) && $past(req[1].valid) && !$past(data_translate_enable)
         |-> resp[1].pa == $past(req[1].ea) && !resp[1].miss;
   endproperty
   a_data_pass: assert property (p_data_pass) else $error("data address altered");
   property p_fetch_vector;
      resp[0].miss |-> resp[0].vector == atu_pkg::VEC_IFETCH_MISS;
   endproperty
   a_fetch_vector: assert property (p_fetch_vector) else $error("fetch miss vector wrong");
   property p_data_vector;
      $past(reset_n) && resp[1].miss |-> resp[1].vector == ($past(req[1].acc) == atu_pkg::ACC_STORE ?
         atu_pkg::VEC_STORE_MISS : atu_pkg::VEC_LOAD_MISS);
   endproperty
   a_data_vector: assert property (p_data_vector) else $error("data miss vector wrong");
   property p_group;
      resp[1].miss |-> resp[1].ptegAddr[5:0] == 6'h00 && resp[1].missVpn[15:0] == $past(req[1].ea[27:12]);
   endproperty
   a_group: assert property (p_group) else $error("search start wrong");
   property p_miss_on;
      resp[1].miss |-> $past(data_translate_enable);
   endproperty
   a_miss_on: assert property (p_miss_on) else $error("miss with translation off");
   property p_page_ofs;
      $past(reset_n) && resp[0].valid && !resp[0].miss && $past(instr_translate_enable)
         |-> resp[0].pa[11:0] == $past(req[0].ea[11:0]);
   endproperty
   a_page_ofs: assert property (p_page_ofs) else $error("page offset altered");
   property p_block_ofs;
      resp[1].blockHit |-> resp[1].pa[16:0] == $past(req[1].ea[16:0]);
   endproperty
   a_block_ofs: assert property (p_block_ofs) else $error("block offset altered");
endmodule
bind address_translation_unit atu_checker u_atu_checker (.mclk(mclk), .reset_n(reset_n),
   .instr_translate_enable(instr_translate_enable), .data_translate_enable(data_translate_enable),
   .req(req), .resp(resp));
`default_nettype wire

// ### verification/atu_core_model.sv
/* Core-side model: fetch unit and load/store first stage.
   Assumes answers are registered on the taking edge and read at the next falling edge, no back-pressure. */
`timescale 1ns/1ps
`default_nettype none
module atu_core_model (
   // Clock
   input  wire logic                     mclk,
   // Requests and answers
   output var  atu_pkg::atu_req_s [1:0]  req,
   input  wire atu_pkg::atu_resp_s [1:0] resp
);
   initial req = '0;
   task automatic access(input int p, input atu_pkg::atu_acc_e acc, input logic user,
                         input logic [31:0] ea, output atu_pkg::atu_resp_s r);
      @(negedge mclk);
      req[p] = '{valid: 1'b1, acc: acc, user: user, ea: ea};
      @(posedge mclk);
      @(negedge mclk);
      r = resp[p];
      // Released address shows its inverse, not the last value
      req[p] = '{valid: 1'b0, acc: acc, user: user, ea: ~ea};
   endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
/* Self-checking bench for the address translation unit.
   Assumes the core model issues requests; maintenance ports are driven here. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] EA1 = 32'h3123_4567;
   localparam logic [31:0] EA2 = 32'h3125_4567;
   localparam logic [31:0] EA3 = 32'h3123_5567;
   localparam logic [31:0] EAB = 32'h7007_1234;
   localparam logic [23:0] VSID = 24'h05_A5A5;
   localparam logic [19:0] PPN1 = 20'hA_BCDE;
   localparam logic [19:0] PPN2 = 20'h1_3579;
   logic                      mclk;
   logic                      reset_n;
   logic                      instr_translate_enable;
   logic                      data_translate_enable;
   atu_pkg::atu_req_s [1:0]   req;
   atu_pkg::atu_resp_s [1:0]  resp;
   logic                      segWrValid;
   logic [3:0]                segWrSel;
   atu_pkg::atu_seg_s         segWrData;
   logic                      batWrValid;
   logic                      batWrToData;
   logic [1:0]                batWrSel;
   atu_pkg::atu_bat_s         batWrData;
   atu_pkg::atu_tcw_s         tcWrite;
   logic                      tcInvValid;
   logic [31:0]               tcInvEa;
   logic [31:0]               htabOrg;
   logic [8:0]                htabMask;
   atu_pkg::atu_resp_s        r;
   int                        numErrors;
   int                        totalChecks;

   address_translation_unit u_address_translation_unit (.mclk(mclk), .reset_n(reset_n),
      .instr_translate_enable(instr_translate_enable), .data_translate_enable(data_translate_enable),
      .req(req), .resp(resp), .segWrValid(segWrValid), .segWrSel(segWrSel), .segWrData(segWrData),
      .batWrValid(batWrValid), .batWrToData(batWrToData), .batWrSel(batWrSel), .batWrData(batWrData),
      .tcWrite(tcWrite), .tcInvValid(tcInvValid), .tcInvEa(tcInvEa), .htabOrg(htabOrg), .htabMask(htabMask));
   atu_core_model u_atu_core_model (.mclk(mclk), .req(req), .resp(resp));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] got);
      totalChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] page_entry_group(input logic [23:0] vsid, input logic [31:0] ea);
      logic [18:0] h;
      h = vsid[18:0] ^ {3'b000, ea[27:12]};
      return htabOrg | {7'h00, h[18:10] & htabMask, h[9:0], 6'h00};
   endfunction

   task automatic chk_resp(input string what, input logic miss, input logic fault, input logic blk,
                           input logic [19:0] vec, input logic [31:0] pa);
      cmp({what, " valid"}, 40'(1'b1), 40'(r.valid));
      cmp({what, " flags"}, 40'({miss, fault, blk}), 40'({r.miss, r.protFault, r.blockHit}));
      cmp({what, " vector"}, 40'(vec), 40'(r.vector));
      if (!miss && !fault) cmp({what, " pa"}, 40'(pa), 40'(r.pa));
   endtask

   task automatic chk_miss(input string what, input logic [23:0] vsid, input logic [31:0] ea);
      cmp({what, " group"}, 40'(page_entry_group(vsid, ea)), 40'(r.ptegAddr));
      cmp({what, " vpn"}, {vsid, ea[27:12]}, r.missVpn);
   endtask

   task automatic tc_fill(input logic toData, input logic [31:0] ea, input logic [19:0] ppn,
                          input logic [1:0] pp, input logic changed);
      @(negedge mclk);
      tcWrite = '{valid: 1'b1, toData: toData, vpn: {VSID, ea[27:12]}, ppn: ppn, pp: pp, changed: changed};
      @(negedge mclk);
      tcWrite.valid = 1'b0;
   endtask

   task automatic bat_load(input logic [10:0] bl, input logic [14:0] brpn, input logic [1:0] pp);
      @(negedge mclk);
      batWrValid = 1'b1;
      batWrToData = 1'b1;
      batWrSel = 2'h2;
      batWrData = '{bepi: EAB[31:17], bl: bl, vs: 1'b1, vp: 1'b0, brpn: brpn, pp: pp};
      @(negedge mclk);
      batWrValid = 1'b0;
   endtask

   task automatic sc_passthru;
      u_atu_core_model.access(0, atu_pkg::ACC_FETCH, 1'b1, EA1, r);
      chk_resp("fetch off", 0, 0, 0, atu_pkg::VEC_NONE, EA1);
      instr_translate_enable = 1'b1;
      u_atu_core_model.access(1, atu_pkg::ACC_STORE, 1'b0, EAB, r);
      chk_resp("store off", 0, 0, 0, atu_pkg::VEC_NONE, EAB);
      data_translate_enable = 1'b1;
   endtask

   task automatic sc_miss;
      atu_pkg::atu_acc_e acc [3] = '{atu_pkg::ACC_LOAD, atu_pkg::ACC_STORE, atu_pkg::ACC_CACHE};
      logic [19:0] vec [3] = '{atu_pkg::VEC_LOAD_MISS, atu_pkg::VEC_STORE_MISS, atu_pkg::VEC_LOAD_MISS};
      @(negedge mclk);
      segWrValid = 1'b1;
      segWrSel = EA1[31:28];
      segWrData = '{ks: 1'b0, kp: 1'b1, vsid: VSID};
      @(negedge mclk);
      segWrValid = 1'b0;
      u_atu_core_model.access(0, atu_pkg::ACC_FETCH, 1'b0, EA1, r);
      chk_resp("fetch miss", 1, 0, 0, atu_pkg::VEC_IFETCH_MISS, '0);
      chk_miss("fetch miss", VSID, EA1);
      for (int i = 0; i < 3; i++) begin
         u_atu_core_model.access(1, acc[i], 1'b0, EA1, r);
         chk_resp("data miss", 1, 0, 0, vec[i], '0);
         chk_miss("data miss", VSID, EA1);
      end
   endtask

   task automatic sc_page;
      tc_fill(1'b0, EA1, PPN1, atu_pkg::PP_RW, 1'b1);
      u_atu_core_model.access(0, atu_pkg::ACC_FETCH, 1'b0, EA1, r);
      chk_resp("fetch hit", 0, 0, 0, atu_pkg::VEC_NONE, {PPN1, EA1[11:0]});
      u_atu_core_model.access(1, atu_pkg::ACC_LOAD, 1'b0, EA1, r);
      chk_resp("data apart", 1, 0, 0, atu_pkg::VEC_LOAD_MISS, '0);
      tc_fill(1'b1, EA1, PPN1, atu_pkg::PP_RW, 1'b0);
      tc_fill(1'b1, EA2, PPN2, atu_pkg::PP_NONE, 1'b1);
      tc_fill(1'b1, EA3, PPN2, atu_pkg::PP_RW, 1'b1);
      u_atu_core_model.access(1, atu_pkg::ACC_STORE, 1'b0, EA1, r);
      chk_resp("store unchanged", 1, 0, 0, atu_pkg::VEC_STORE_MISS, '0);
      u_atu_core_model.access(1, atu_pkg::ACC_LOAD, 1'b1, EA1, r);
      chk_resp("user load", 0, 0, 0, atu_pkg::VEC_NONE, {PPN1, EA1[11:0]});
      u_atu_core_model.access(1, atu_pkg::ACC_LOAD, 1'b1, EA2, r);
      chk_resp("user denied", 0, 1, 0, atu_pkg::VEC_NONE, '0);
      u_atu_core_model.access(1, atu_pkg::ACC_LOAD, 1'b0, EA2, r);
      chk_resp("super read", 0, 0, 0, atu_pkg::VEC_NONE, {PPN2, EA2[11:0]});
   endtask

   task automatic sc_inval;
      @(negedge mclk);
      tcInvValid = 1'b1;
      tcInvEa = EA1;
      @(negedge mclk);
      tcInvValid = 1'b0;
      u_atu_core_model.access(0, atu_pkg::ACC_FETCH, 1'b0, EA1, r);
      chk_resp("fetch gone", 1, 0, 0, atu_pkg::VEC_IFETCH_MISS, '0);
      u_atu_core_model.access(1, atu_pkg::ACC_LOAD, 1'b0, EA2, r);
      chk_resp("data gone", 1, 0, 0, atu_pkg::VEC_LOAD_MISS, '0);
      u_atu_core_model.access(1, atu_pkg::ACC_LOAD, 1'b0, EA3, r);
      chk_resp("other set kept", 0, 0, 0, atu_pkg::VEC_NONE, {PPN2, EA3[11:0]});
   endtask

   task automatic sc_block;
      bat_load(11'h000, 15'h0155, 2'h1);
      u_atu_core_model.access(1, atu_pkg::ACC_LOAD, 1'b0, EAB, r);
      chk_resp("block load", 0, 0, 1, atu_pkg::VEC_NONE, {15'h0155, EAB[16:0]});
      u_atu_core_model.access(1, atu_pkg::ACC_STORE, 1'b0, EAB, r);
      chk_resp("block store", 0, 1, 1, atu_pkg::VEC_NONE, '0);
      u_atu_core_model.access(1, atu_pkg::ACC_LOAD, 1'b1, EAB, r);
      chk_resp("block user", 1, 0, 0, atu_pkg::VEC_LOAD_MISS, '0);
      u_atu_core_model.access(0, atu_pkg::ACC_FETCH, 1'b0, EAB, r);
      chk_resp("block fetch", 1, 0, 0, atu_pkg::VEC_IFETCH_MISS, '0);
      bat_load(11'h7FF, 15'h4000, atu_pkg::PP_RW);
      u_atu_core_model.access(1, atu_pkg::ACC_STORE, 1'b0, 32'h7ABC_DEF0, r);
      chk_resp("block large", 0, 0, 1, atu_pkg::VEC_NONE, 32'h8ABC_DEF0);
   endtask

   task automatic close_out;
      if (numErrors == 0 && totalChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge mclk);
      numErrors++;
      close_out;
   end

   initial begin
      reset_n = 1'b0;
      instr_translate_enable = 1'b0;
      data_translate_enable = 1'b0;
      segWrValid = 1'b0;
      segWrSel = '0;
      segWrData = '0;
      batWrValid = 1'b0;
      batWrToData = 1'b0;
      batWrSel = '0;
      batWrData = '0;
      tcWrite = '0;
      tcInvValid = 1'b0;
      tcInvEa = '0;
      htabOrg = 32'h0400_0000;
      htabMask = 9'h00F;
      numErrors = 0;
      totalChecks = 0;
      repeat (10) @(negedge mclk);
      cmp("reset answer", 40'h00_0000_0000, 40'({resp[1].valid, resp[0].valid, resp[1].pa}));
      reset_n = 1'b1;
      sc_passthru;
      sc_miss;
      sc_page;
      sc_inval;
      sc_block;
      close_out;
   end
endmodule
`default_nettype wire
